/* hdl/flash_self_program_pkg.sv */
// Constants for the flash self-programming controller
package flash_self_program_pkg;
   // Register indices on the special-register port
   localparam logic [4:0] REG_MAIN_CTRL = 5'h00;
   localparam logic [4:0] REG_RESET_PAT = 5'h01;
   localparam logic [4:0] REG_BUF_CLEAR = 5'h02;
   localparam logic [4:0] REG_ADDR_LOW = 5'h03;
   localparam logic [4:0] REG_ADDR_HIGH = 5'h04;
   localparam logic [4:0] REG_DATA0_LOW = 5'h05;
   localparam logic [4:0] REG_DATA0_HIGH = 5'h06;
   localparam logic [4:0] REG_DATA1_LOW = 5'h07;
   localparam logic [4:0] REG_DATA3_HIGH = 5'h0C;
   // Main control field positions
   localparam int BIT_WEN_STATUS = 7;
   localparam int BIT_MODE_HI = 6;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_PROC_EN = 3;
   localparam int BIT_WRITE_GO = 2;
   localparam int BIT_READ_EN = 1;
   localparam int BIT_READ_GO = 0;
   // Mode field codes
   typedef enum logic [2:0] {
      MODE_WRITE = 3'b000,
      MODE_ERASE = 3'b001,
      MODE_RSV2 = 3'b010,
      MODE_READ = 3'b011,
      MODE_RSV4 = 3'b100,
      MODE_RSV5 = 3'b101,
      MODE_UNLOCK = 3'b110,
      MODE_RSV7 = 3'b111
   } op_mode_t;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
   // Unlock byte sequence, data word 1 low to data word 3 high
   localparam logic [47:0] UNLOCK_SEQ = 48'h00040D09C340;
   // Address width options: 13,14,15,16 bits
   localparam int ADDR_BITS = 16;
   // Unlock window measured in low-speed oscillator ticks
   localparam int UNLOCK_TIMEOUT_US = 300;
   localparam int SLOW_OSC_KHZ = 32;
   localparam int UNLOCK_TICKS = (UNLOCK_TIMEOUT_US * SLOW_OSC_KHZ) / 1000;
   // Cycles that the buffer clear takes
   localparam logic [3:0] BUF_CLEAR_CYCLES = 4'h4;
endpackage

/* hdl/flash_self_program_ctrl.sv */
// Flash in-application programming controller
`timescale 1ns/1ps
module flash_self_program_ctrl #(
   parameter int ADDR_W = flash_self_program_pkg::ADDR_BITS,
   parameter int PAGE_WORDS = 128
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic slow_tick,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic flash_done,
   input wire logic [15:0] flash_rdata,
   output logic flash_write,
   output logic flash_erase,
   output logic flash_read,
   output logic [15:0] flash_addr,
   output logic [15:0] buf_wdata,
   output logic buf_load,
   output logic buf_clear,
   output logic cpu_stall,
   output logic chip_reset
);
   localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_W) - 1);
   localparam logic [15:0] PAGE_MASK = 16'(~(PAGE_WORDS - 1));

   logic [7:0] addr_low_reg, addr_high_reg, reset_pat_reg;
   logic [7:0] ctrl_reg;
   logic clear_go_reg;
   logic [3:0] clear_cnt_reg;
   logic [7:0] data_low_reg [4];
   logic [7:0] data_high_reg [4];
   logic flash_busy_reg;
   logic unlock_active_reg;
   logic [2:0] unlock_idx_reg;
   logic unlock_bad_reg;
   logic [15:0] unlock_cnt_reg;
   logic [15:0] addr_full;
   logic [2:0] mode;
   logic wr_ctrl, wr_low0, wr_high0;
   logic unlock_wr;
   logic [7:0] unlock_byte;
   logic [47:0] seq_shift;

   assign addr_full = {addr_high_reg, addr_low_reg} & ADDR_MASK;
   assign mode = ctrl_reg[flash_self_program_pkg::BIT_MODE_HI:
                          flash_self_program_pkg::BIT_MODE_LO];
   assign wr_ctrl = reg_wr && reg_addr == flash_self_program_pkg::REG_MAIN_CTRL;
   assign wr_low0 = reg_wr && reg_addr == flash_self_program_pkg::REG_DATA0_LOW;
   assign wr_high0 = reg_wr &&
      reg_addr == flash_self_program_pkg::REG_DATA0_HIGH;
   // Writes to data words one to three feed the unlock checker
   assign unlock_wr = reg_wr &&
      reg_addr >= flash_self_program_pkg::REG_DATA1_LOW &&
      reg_addr <= flash_self_program_pkg::REG_DATA3_HIGH;
   assign seq_shift = flash_self_program_pkg::UNLOCK_SEQ << {unlock_idx_reg, 3'b000};
   assign unlock_byte = seq_shift[47:40];

   // Data word registers, one generate slice per word
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_word
         localparam logic [4:0] LO =
            5'(flash_self_program_pkg::REG_DATA0_LOW + 2 * gi);
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               data_low_reg[gi] <= flash_self_program_pkg::RESET_VALUE;
               data_high_reg[gi] <= flash_self_program_pkg::RESET_VALUE;
            end else if (reg_wr && reg_addr == LO) begin
               data_low_reg[gi] <= reg_wdata;
            end else if (reg_wr && reg_addr == 5'(LO + 1)) begin
               data_high_reg[gi] <= reg_wdata;
            end else if (gi == 0 && flash_read && flash_done) begin
               data_low_reg[gi] <= flash_rdata[7:0];
               data_high_reg[gi] <= flash_rdata[15:8];
            end
         end
      end
   endgenerate

   // Address pair, auto-increment on data word 0 high write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_low_reg <= flash_self_program_pkg::RESET_VALUE;
         addr_high_reg <= flash_self_program_pkg::RESET_VALUE;
      end else if (wr_high0) begin
         {addr_high_reg, addr_low_reg} <= (addr_full + 16'h0001) & ADDR_MASK;
      end else if (reg_wr &&
                   reg_addr == flash_self_program_pkg::REG_ADDR_LOW) begin
         addr_low_reg <= reg_wdata;
      end else if (reg_wr &&
                   reg_addr == flash_self_program_pkg::REG_ADDR_HIGH) begin
         addr_high_reg <= reg_wdata & ADDR_MASK[15:8];
      end
   end

   // Buffer load strobe and data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         buf_load <= 1'b0;
         buf_wdata <= 16'h0000;
      end else begin
         buf_load <= wr_high0;
         buf_wdata <= {reg_wdata, data_low_reg[0]};
      end
   end

   // Reset pattern register and chip reset pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reset_pat_reg <= flash_self_program_pkg::RESET_VALUE;
         chip_reset <= 1'b0;
      end else begin
         chip_reset <= reg_wr &&
            reg_addr == flash_self_program_pkg::REG_RESET_PAT &&
            reg_wdata == flash_self_program_pkg::CHIP_RESET_KEY;
         if (reg_wr && reg_addr == flash_self_program_pkg::REG_RESET_PAT) begin
            reset_pat_reg <= reg_wdata;
         end
      end
   end

   // Buffer clear bit and its timed process
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clear_go_reg <= 1'b0;
         clear_cnt_reg <= 4'h0;
         buf_clear <= 1'b0;
      end else if (clear_go_reg) begin
         buf_clear <= 1'b1;
         clear_cnt_reg <= clear_cnt_reg + 4'h1;
         if (clear_cnt_reg == flash_self_program_pkg::BUF_CLEAR_CYCLES - 4'h1) begin
            clear_go_reg <= 1'b0;
            buf_clear <= 1'b0;
         end
      end else begin
         clear_cnt_reg <= 4'h0;
         buf_clear <= 1'b0;
         if (reg_wr && reg_addr == flash_self_program_pkg::REG_BUF_CLEAR) begin
            clear_go_reg <= reg_wdata[0];
         end
      end
   end

   // Unlock checker: byte index, mismatch flag, slow-clock timeout
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         unlock_active_reg <= 1'b0;
         unlock_idx_reg <= 3'h0;
         unlock_bad_reg <= 1'b0;
         unlock_cnt_reg <= 16'h0000;
      end else if (!unlock_active_reg) begin
         unlock_idx_reg <= 3'h0;
         unlock_bad_reg <= 1'b0;
         unlock_cnt_reg <= 16'h0000;
         unlock_active_reg <= ctrl_reg[flash_self_program_pkg::BIT_PROC_EN] &&
            mode == flash_self_program_pkg::MODE_UNLOCK;
      end else begin
         if (slow_tick) begin
            unlock_cnt_reg <= unlock_cnt_reg + 16'h0001;
         end
         if (unlock_wr) begin
            unlock_idx_reg <= unlock_idx_reg + 3'h1;
            if (reg_wdata != unlock_byte) begin
               unlock_bad_reg <= 1'b1;
            end
         end
         if (unlock_idx_reg == 3'h6 ||
             unlock_cnt_reg >= 16'(flash_self_program_pkg::UNLOCK_TICKS)) begin
            unlock_active_reg <= 1'b0;
         end
      end
   end

   // Main control register with hardware set and clear terms
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= flash_self_program_pkg::RESET_VALUE;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg[6:0] <= reg_wdata[6:0];
            if (!reg_wdata[flash_self_program_pkg::BIT_WEN_STATUS]) begin
               ctrl_reg[flash_self_program_pkg::BIT_WEN_STATUS] <= 1'b0;
            end
         end
         if (unlock_active_reg && (unlock_idx_reg == 3'h6 ||
             unlock_cnt_reg >= 16'(flash_self_program_pkg::UNLOCK_TICKS))) begin
            ctrl_reg[flash_self_program_pkg::BIT_PROC_EN] <= 1'b0;
            if (unlock_idx_reg == 3'h6 && !unlock_bad_reg &&
                unlock_cnt_reg < 16'(flash_self_program_pkg::UNLOCK_TICKS)) begin
               ctrl_reg[flash_self_program_pkg::BIT_WEN_STATUS] <= 1'b1;
            end
         end
         if (flash_busy_reg && flash_done) begin
            ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] <= 1'b0;
            ctrl_reg[flash_self_program_pkg::BIT_READ_GO] <= 1'b0;
         end
         if (!flash_busy_reg && ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] &&
             !(ctrl_reg[flash_self_program_pkg::BIT_WEN_STATUS] &&
               (mode == flash_self_program_pkg::MODE_WRITE ||
                mode == flash_self_program_pkg::MODE_ERASE))) begin
            ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] <= 1'b0;
         end
         if (!flash_busy_reg && ctrl_reg[flash_self_program_pkg::BIT_READ_GO] &&
             !(ctrl_reg[flash_self_program_pkg::BIT_READ_EN] &&
               mode == flash_self_program_pkg::MODE_READ)) begin
            ctrl_reg[flash_self_program_pkg::BIT_READ_GO] <= 1'b0;
         end
      end
   end

   // Flash operation launch and hold until done
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_busy_reg <= 1'b0;
         flash_write <= 1'b0;
         flash_erase <= 1'b0;
         flash_read <= 1'b0;
         flash_addr <= 16'h0000;
      end else if (flash_busy_reg) begin
         if (flash_done) begin
            flash_busy_reg <= 1'b0;
            flash_write <= 1'b0;
            flash_erase <= 1'b0;
            flash_read <= 1'b0;
         end
      end else if (ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] &&
                   ctrl_reg[flash_self_program_pkg::BIT_WEN_STATUS] &&
                   mode == flash_self_program_pkg::MODE_WRITE) begin
         flash_busy_reg <= 1'b1;
         flash_write <= 1'b1;
         flash_addr <= addr_full;
      end else if (ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] &&
                   ctrl_reg[flash_self_program_pkg::BIT_WEN_STATUS] &&
                   mode == flash_self_program_pkg::MODE_ERASE) begin
         flash_busy_reg <= 1'b1;
         flash_erase <= 1'b1;
         flash_addr <= addr_full & PAGE_MASK;
      end else if (ctrl_reg[flash_self_program_pkg::BIT_READ_GO] &&
                   ctrl_reg[flash_self_program_pkg::BIT_READ_EN] &&
                   mode == flash_self_program_pkg::MODE_READ) begin
         flash_busy_reg <= 1'b1;
         flash_read <= 1'b1;
         flash_addr <= addr_full;
      end
   end

   // Core stall follows the initiate bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= ctrl_reg[flash_self_program_pkg::BIT_WRITE_GO] ||
            ctrl_reg[flash_self_program_pkg::BIT_READ_GO];
      end
   end

   // Registered read data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            5'h00: reg_rdata <= ctrl_reg;
            5'h01: reg_rdata <= reset_pat_reg;
            5'h02: reg_rdata <= {7'h00, clear_go_reg};
            5'h03: reg_rdata <= addr_low_reg;
            5'h04: reg_rdata <= addr_high_reg;
            5'h05, 5'h07, 5'h09, 5'h0B:
               reg_rdata <= data_low_reg[reg_addr[2:1] - 2'h2];
            5'h06, 5'h08, 5'h0A, 5'h0C:
               reg_rdata <= data_high_reg[reg_addr[2:1] - 2'h3];
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   a_wen_only_unlock: assert property (@(posedge mclk) disable iff (rst)
      $rose(ctrl_reg[7]) |-> $past(unlock_active_reg) && !$past(unlock_bad_reg))
      else $error("write status set without good unlock");
   a_locked_no_write: assert property (@(posedge mclk) disable iff (rst)
      $rose(flash_write) || $rose(flash_erase) |-> $past(ctrl_reg[7]))
      else $error("flash written while locked");
   a_reset_key: assert property (@(posedge mclk) disable iff (rst)
      chip_reset |-> $past(reg_wdata) == 8'h55 && $past(reg_wr))
      else $error("chip reset without key");
   a_addr_incr: assert property (@(posedge mclk) disable iff (rst)
      wr_high0 |=> addr_full == (($past(addr_full) + 16'h0001) & ADDR_MASK))
      else $error("address not incremented");
   a_low_no_load: assert property (@(posedge mclk) disable iff (rst)
      wr_low0 && !wr_high0 |=> !buf_load)
      else $error("low byte loaded buffer");
   a_clear_ends: assert property (@(posedge mclk) disable iff (rst)
      $rose(clear_go_reg) |-> ##[1:5] !clear_go_reg)
      else $error("buffer clear never ended");
   a_stall_follows: assert property (@(posedge mclk) disable iff (rst)
      ctrl_reg[2] || ctrl_reg[0] |=> cpu_stall)
      else $error("core not stalled");
   a_proc_end_clears: assert property (@(posedge mclk) disable iff (rst)
      $fell(unlock_active_reg) |-> !ctrl_reg[3])
      else $error("procedure enable left set");
   a_no_read_locked: assert property (@(posedge mclk) disable iff (rst)
      $rose(flash_read) |-> $past(ctrl_reg[1]))
      else $error("read without enable");
   c_unlock_ok: cover property (@(posedge mclk) disable iff (rst)
      $rose(ctrl_reg[7]));
   c_write_done: cover property (@(posedge mclk) disable iff (rst)
      $fell(flash_write));
   c_read_done: cover property (@(posedge mclk) disable iff (rst)
      $fell(flash_read));
endmodule // flash_self_program_ctrl

/* testbench/flash_array_model.sv */
// Behavioural model of the flash array behind the controller
`timescale 1ns/1ps
module flash_array_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic slow,
   input wire logic flash_write,
   input wire logic flash_erase,
   input wire logic flash_read,
   input wire logic [15:0] flash_addr,
   output logic flash_done,
   output logic [15:0] flash_rdata
);
   logic [7:0] cnt;
   logic hold;
   logic busy;
   assign busy = flash_write | flash_erase | flash_read;
   // One done pulse per request, after a short or a long delay
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 8'h00;
         hold <= 1'b0;
         flash_done <= 1'b0;
         flash_rdata <= 16'h0000;
      end else begin
         flash_done <= 1'b0;
         if (!busy) begin
            hold <= 1'b0;
            cnt <= 8'h00;
            flash_rdata <= ~flash_rdata; // Idle bus never holds a value
         end else if (!hold) begin
            if (cnt == (slow ? 8'h09 : 8'h02)) begin
               flash_done <= 1'b1;
               hold <= 1'b1;
               if (flash_read) flash_rdata <= flash_addr ^ 16'h5A3C;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule // flash_array_model

/* testbench/test_flash_self_program_ctrl.sv */
// Self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module test_flash_self_program_ctrl;
   // Direct index stands in for the pointer pair reaching the control block
   localparam logic [4:0] CTRL = flash_self_program_pkg::REG_MAIN_CTRL;
   localparam logic [4:0] RPAT = flash_self_program_pkg::REG_RESET_PAT;
   localparam logic [4:0] BCLR = flash_self_program_pkg::REG_BUF_CLEAR;
   localparam logic [4:0] ALO = flash_self_program_pkg::REG_ADDR_LOW;
   localparam logic [4:0] AHI = flash_self_program_pkg::REG_ADDR_HIGH;
   localparam logic [4:0] D0L = flash_self_program_pkg::REG_DATA0_LOW;
   localparam logic [4:0] D0H = flash_self_program_pkg::REG_DATA0_HIGH;
   localparam logic [4:0] D1L = flash_self_program_pkg::REG_DATA1_LOW;
   logic mclk, rst, slow_tick, reg_wr, reg_rd, flash_done, flash_write;
   logic flash_erase, flash_read, buf_load, buf_clear, cpu_stall;
   logic chip_reset, slow, rd_seen, saw_op, saw_stall;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, ah, al, na, d_lo, d_hi;
   logic [15:0] flash_rdata, flash_addr, buf_wdata, ea, e;
   logic [15:0] rd_q[$];
   logic [15:0] ld_q[$];
   int n_errors, compares, cyc, n_rst, i;

   flash_self_program_ctrl #(.ADDR_W(13), .PAGE_WORDS(32))
      flash_self_program_ctrl_i (.mclk(mclk), .rst(rst),
      .slow_tick(slow_tick), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .flash_done(flash_done), .flash_rdata(flash_rdata),
      .flash_write(flash_write), .flash_erase(flash_erase),
      .flash_read(flash_read), .flash_addr(flash_addr),
      .buf_wdata(buf_wdata), .buf_load(buf_load), .buf_clear(buf_clear),
      .cpu_stall(cpu_stall), .chip_reset(chip_reset));
   flash_array_model flash_array_model_i (.mclk(mclk), .rst(rst),
      .slow(slow), .flash_write(flash_write), .flash_erase(flash_erase),
      .flash_read(flash_read), .flash_addr(flash_addr),
      .flash_done(flash_done), .flash_rdata(flash_rdata));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] x);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rd_q.push_back({8'h00, x});
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic tick();
      @(posedge mclk);
      slow_tick <= 1'b1;
      @(posedge mclk);
      slow_tick <= 1'b0;
   endtask
   task automatic done(input string name);
      idle(3);
      $display("test %s done", name);
   endtask
   // Starts an operation and follows it to its end
   task automatic run_op(input logic [7:0] c, input logic go);
      int k;
      saw_op = 1'b0;
      saw_stall = 1'b0;
      wr(CTRL, c);
      for (k = 0; k < 40; k++) begin
         @(negedge mclk);
         if (flash_write | flash_erase | flash_read) saw_op = 1'b1;
         if (cpu_stall) saw_stall = 1'b1;
         if (flash_erase) chk("erase address", flash_addr, ea);
         if (flash_write) chk("write address", flash_addr, ea);
         if (flash_read) chk("read address", flash_addr, ea);
         if (saw_op && !(flash_write | flash_erase | flash_read)
            && !cpu_stall) break;
      end
      chk("op started", {15'h0, saw_op}, {15'h0, go});
      if (go) chk("stall", {15'h0, saw_stall}, 16'h0001);
   endtask

   // Result monitor: oldest note against each result
   always @(posedge mclk) rd_seen <= reg_rd;
   always @(negedge mclk) begin
      if (rd_seen && rd_q.size() > 0) begin
         chk("reg_rdata", {8'h00, reg_rdata}, rd_q.pop_front());
      end
      if (buf_load && ld_q.size() > 0) begin
         chk("buf_wdata", buf_wdata, ld_q.pop_front());
      end else if (buf_load) begin
         chk("buf_load", 16'h0001, 16'h0000);
      end
      if (chip_reset) n_rst++;
   end
   // Watchdog
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      slow_tick = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      slow = 1'b0;
      ea = 16'h0000;
      void'($urandom(21));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i <= 12; i++) rd(i[4:0], 8'h00);
      rd(5'h1F, 8'h00);
      wr(AHI, 8'hFF);
      rd(AHI, 8'h1F);
      wr(BCLR, 8'hFE);
      rd(BCLR, 8'h00);
      wr(CTRL, 8'h80);
      rd(CTRL, 8'h00);
      done("reset and fields");
      wr(BCLR, 8'h01);
      for (i = 0; i < 10 && buf_clear !== 1'b1; i++) @(negedge mclk);
      chk("buf_clear", {15'h0, buf_clear}, 16'h0001);
      for (i = 0; i < 20 && buf_clear !== 1'b0; i++) @(negedge mclk);
      rd(BCLR, 8'h00);
      run_op(8'h04, 1'b0);
      rd(CTRL, 8'h00);
      run_op(8'h14, 1'b0);
      rd(CTRL, 8'h10);
      done("buffer clear and locked ops");
      wr(CTRL, 8'h68);
      wr(D1L, 8'h01);
      for (i = 1; i < 6; i++) begin
         wr(D1L + i[4:0], flash_self_program_pkg::UNLOCK_SEQ[47-8*i -: 8]);
      end
      idle(4);
      rd(CTRL, 8'h60);
      wr(CTRL, 8'h68);
      repeat (12) tick();
      rd(CTRL, 8'h60);
      wr(CTRL, 8'h68);
      for (i = 0; i < 6; i++) begin
         wr(D1L + i[4:0], flash_self_program_pkg::UNLOCK_SEQ[47-8*i -: 8]);
      end
      idle(4);
      rd(CTRL, 8'hE0);
      for (i = 0; i < 8; i++) begin
         if (i == 2 || i == 4 || i == 5 || i == 7) begin
            run_op({1'b1, i[2:0], 4'h4}, 1'b0);
            rd(CTRL, {1'b1, i[2:0], 4'h0});
         end
      end
      done("unlock and modes");
      ah = 8'($urandom % 32);
      al = 8'($urandom % 255);
      d_lo = 8'($urandom);
      d_hi = 8'($urandom);
      na = al + 8'h01;
      wr(ALO, al);
      wr(AHI, ah);
      wr(D0L, d_lo);
      idle(2);
      ld_q.push_back({d_hi, d_lo});
      wr(D0H, d_hi);
      idle(2);
      rd(ALO, na);
      rd(AHI, ah);
      ea = {3'h0, ah[4:0], na};
      run_op(8'h84, 1'b1);
      rd(CTRL, 8'h80);
      slow = 1'b1;
      ea = {3'h0, ah[4:0], na[7:5], 5'h00};
      run_op(8'h94, 1'b1);
      rd(CTRL, 8'h90);
      run_op(8'hB1, 1'b0);
      rd(CTRL, 8'hB0);
      slow = 1'b0;
      ea = {3'h0, ah[4:0], na};
      run_op(8'hB3, 1'b1);
      rd(CTRL, 8'hB2);
      e = {3'h0, ah[4:0], na} ^ 16'h5A3C;
      rd(D0L, e[7:0]);
      rd(D0H, e[15:8]);
      wr(CTRL, 8'h00);
      rd(CTRL, 8'h00);
      ea = 16'h0000;
      run_op(8'h04, 1'b0);
      done("load, write, erase, read");
      wr(RPAT, 8'h54);
      idle(3);
      chk("chip_reset count", 16'(n_rst), 16'h0000);
      wr(RPAT, 8'h55);
      idle(3);
      chk("chip_reset count", 16'(n_rst), 16'h0001);
      @(posedge mclk);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      rd(RPAT, 8'h00);
      done("chip reset");
      stop_test();
   end
endmodule // test_flash_self_program_ctrl
